// [hdl/txscp_top.sv]
`timescale 1ns/10ps
module txscp_top (
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic        i_por_done,
   input  wire logic        i_select_n,
   input  wire logic        i_sck,
   input  wire logic        i_sdi,
   input  wire logic [15:0] i_status,
   output logic             o_sdo,
   output logic [15:0]      o_cfg_word,
   output logic [15:0]      o_freq_word,
   output logic [15:0]      o_pwr_word,
   output logic [15:0]      o_fifo_set_word,
   output logic [15:0]      o_rate_word,
   output logic [15:0]      o_batt_word,
   output logic [15:0]      o_wake_word,
   output logic [15:0]      o_xwake_word,
   output logic [15:0]      o_xfeat_word,
   output logic [1:0]       o_pll_bandwidth_select,
   output logic [2:0]       o_power_step,
   output logic [4:0]       o_power_atten_db,
   output logic [2:0]       o_tune_state,
   output logic             o_fifo_bit_valid,
   output logic             o_fifo_bit_data
);
   logic                    sck_s1_q, sck_s2_q, sck_s3_q;
   logic                    sel_s1_q, sel_s2_q;
   logic                    sdi_s1_q, sdi_s2_q;
   logic                    active, shift_en, commit;
   logic [15:0]             word_d;
   logic [15:0]             sh_q;
   logic [4:0]              cnt_q;
   logic [15:0]             stat_sh_q;
   logic                    sdo_q;
   logic                    fifo_v_q, fifo_d_q;
   txscp_pkg::txscp_state_t st_q;
   txscp_pkg::txscp_cmd_t   cmd_q;
   logic [15:0]             cfg_q, freq_q, pwr_q, fifos_q, rate_q, batt_q, wake_q, xwake_q, xfeat_q;
   logic [2:0]              tune_q, tune_target;
   logic [7:0]              tick_cnt_q;
   logic                    tune_tick;

   // two-flop synchronisers; the third sck flop only feeds the edge detector
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         sel_s1_q <= 1'b1;
         sel_s2_q <= 1'b1;
         sdi_s1_q <= 1'b0;
         sdi_s2_q <= 1'b0;
      end else begin
         sck_s1_q <= i_sck;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         sel_s1_q <= i_select_n;
         sel_s2_q <= sel_s1_q;
         sdi_s1_q <= i_sdi;
         sdi_s2_q <= sdi_s1_q;
      end
   end

   // selected and out of power-on reset; sck rise taken from synced copies
   assign active   = !sel_s2_q && i_por_done;
   assign shift_en = active && sck_s2_q && !sck_s3_q;
   assign word_d   = {sh_q[14:0], sdi_s2_q};
   assign commit   = shift_en && (st_q == txscp_pkg::ST_PARAM) && (cnt_q == txscp_pkg::WORD_BITS - 5'h01);

   // shift register, bit counter and transfer state
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sh_q  <= 16'h0000;
         cnt_q <= 5'h00;
         st_q  <= txscp_pkg::ST_CMD;
         cmd_q <= txscp_pkg::CMD_NONE;
      end else if (!active) begin
         cnt_q <= 5'h00;
         st_q  <= txscp_pkg::ST_CMD;
         cmd_q <= txscp_pkg::CMD_NONE;
      end else if (shift_en) begin
         sh_q <= word_d;
         case (st_q)
            txscp_pkg::ST_CMD: begin
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == txscp_pkg::CMD_BITS - 5'h01) begin
                  cmd_q <= txscp_pkg::txscp_decode(word_d[7:0]);
                  case (txscp_pkg::txscp_decode(word_d[7:0]))
                     txscp_pkg::CMD_FIFOW: st_q <= txscp_pkg::ST_FIFO;
                     txscp_pkg::CMD_STAT:  st_q <= txscp_pkg::ST_STAT;
                     txscp_pkg::CMD_NONE:  st_q <= txscp_pkg::ST_HOLD;
                     default:              st_q <= txscp_pkg::ST_PARAM;
                  endcase
               end
            end
            txscp_pkg::ST_PARAM: begin
               cnt_q <= cnt_q + 5'h01;
               if (commit)
                  st_q <= txscp_pkg::ST_HOLD;
            end
            txscp_pkg::ST_STAT: begin
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == txscp_pkg::CMD_BITS + txscp_pkg::STAT_BITS - 5'h01)
                  st_q <= txscp_pkg::ST_HOLD;
            end
            txscp_pkg::ST_FIFO: cnt_q <= cnt_q;
            txscp_pkg::ST_HOLD: cnt_q <= cnt_q;
            default:            st_q <= txscp_pkg::ST_HOLD;
         endcase
      end
   end

   // command registers; written only when the last parameter bit lands
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cfg_q   <= txscp_pkg::CFG_POR;
         freq_q  <= txscp_pkg::FREQ_POR;
         pwr_q   <= txscp_pkg::PWR_POR;
         fifos_q <= txscp_pkg::FIFOS_POR;
         rate_q  <= txscp_pkg::RATE_POR;
         batt_q  <= txscp_pkg::BATT_POR;
         wake_q  <= txscp_pkg::WAKE_POR;
         xwake_q <= txscp_pkg::XWAKE_POR;
         xfeat_q <= txscp_pkg::XFEAT_POR;
      end else if (commit) begin
         case (cmd_q)
            txscp_pkg::CMD_CFG:   cfg_q   <= txscp_pkg::txscp_merge(txscp_pkg::CFG_POR, txscp_pkg::MASK_12, word_d);
            txscp_pkg::CMD_FREQ: begin
               // out-of-range frequency words keep the previous value
               if (word_d[11:0] >= txscp_pkg::FREQ_MIN && word_d[11:0] <= txscp_pkg::FREQ_MAX)
                  freq_q <= txscp_pkg::txscp_merge(txscp_pkg::FREQ_POR, txscp_pkg::MASK_12, word_d);
            end
            txscp_pkg::CMD_PWR:   pwr_q   <= txscp_pkg::txscp_merge(txscp_pkg::PWR_POR, txscp_pkg::MASK_PWR, word_d);
            txscp_pkg::CMD_FIFOS: fifos_q <= txscp_pkg::txscp_merge(txscp_pkg::FIFOS_POR, txscp_pkg::MASK_FS, word_d);
            txscp_pkg::CMD_RATE:  rate_q  <= txscp_pkg::txscp_merge(txscp_pkg::RATE_POR, txscp_pkg::MASK_8, word_d);
            txscp_pkg::CMD_BATT:  batt_q  <= txscp_pkg::txscp_merge(txscp_pkg::BATT_POR, txscp_pkg::MASK_8, word_d);
            txscp_pkg::CMD_WAKE:  wake_q  <= txscp_pkg::txscp_merge(txscp_pkg::WAKE_POR, txscp_pkg::MASK_12, word_d);
            txscp_pkg::CMD_XWAKE: xwake_q <= txscp_pkg::txscp_merge(txscp_pkg::XWAKE_POR, txscp_pkg::MASK_8, word_d);
            txscp_pkg::CMD_XFEAT: xfeat_q <= txscp_pkg::txscp_merge(txscp_pkg::XFEAT_POR, txscp_pkg::MASK_8, word_d);
            default:              cfg_q   <= cfg_q;
         endcase
      end
   end

   // fifo data bits pass straight out, one pulse per serial bit
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fifo_v_q <= 1'b0;
         fifo_d_q <= 1'b0;
      end else begin
         fifo_v_q <= shift_en && (st_q == txscp_pkg::ST_FIFO);
         if (shift_en && (st_q == txscp_pkg::ST_FIFO))
            fifo_d_q <= sdi_s2_q;
      end
   end

   // status shifter: bit 15 appears after the command byte, next bit after each rise
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         stat_sh_q <= 16'h0000;
         sdo_q     <= 1'b0;
      end else if (!active) begin
         sdo_q <= 1'b0;
      end else if (shift_en && st_q == txscp_pkg::ST_CMD && cnt_q == txscp_pkg::CMD_BITS - 5'h01
                   && txscp_pkg::txscp_decode(word_d[7:0]) == txscp_pkg::CMD_STAT) begin
         stat_sh_q <= {i_status[14:0], 1'b0};
         sdo_q     <= i_status[15];
      end else if (shift_en && st_q == txscp_pkg::ST_STAT) begin
         sdo_q     <= stat_sh_q[15];
         stat_sh_q <= {stat_sh_q[14:0], 1'b0};
      end
   end

   // antenna tuning walks one state per tick toward the carrier's target
   assign tune_target = freq_q[txscp_pkg::TUNE_LSB +: 3];
   assign tune_tick   = (tick_cnt_q == 8'(txscp_pkg::TUNE_STEP_CYCLES - 1));
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tick_cnt_q <= 8'h00;
         tune_q     <= 3'h0;
      end else begin
         tick_cnt_q <= tune_tick ? 8'h00 : tick_cnt_q + 8'h01;
         if (tune_tick && tune_q < tune_target)
            tune_q <= tune_q + 3'h1;
         else if (tune_tick && tune_q > tune_target)
            tune_q <= tune_q - 3'h1;
      end
   end

   assign o_sdo                  = sdo_q;
   assign o_cfg_word             = cfg_q;
   assign o_freq_word            = freq_q;
   assign o_pwr_word             = pwr_q;
   assign o_fifo_set_word        = fifos_q;
   assign o_rate_word            = rate_q;
   assign o_batt_word            = batt_q;
   assign o_wake_word            = wake_q;
   assign o_xwake_word           = xwake_q;
   assign o_xfeat_word           = xfeat_q;
   assign o_pll_bandwidth_select = xfeat_q[txscp_pkg::PLLBW_LSB +: 2];
   assign o_power_step           = cfg_q[txscp_pkg::PWR_STEP_LSB +: 3];
   assign o_power_atten_db       = 5'({2'b00, o_power_step} * txscp_pkg::DB_PER_STEP);
   assign o_tune_state           = tune_q;
   assign o_fifo_bit_valid       = fifo_v_q;
   assign o_fifo_bit_data        = fifo_d_q;

   // checks
   property p_sel_clear;
      @(posedge i_clk) disable iff (i_reset) (sel_s2_q) |=> (cnt_q == 5'h00 && st_q == txscp_pkg::ST_CMD);
   endproperty
   a_sel_clear: assert property (p_sel_clear) else $error("select high did not reset interface");
   property p_shift;
      @(posedge i_clk) disable iff (i_reset) shift_en |=> (sh_q[0] == $past(sdi_s2_q) && sh_q[15:1] == $past(sh_q[14:0]));
   endproperty
   a_shift: assert property (p_shift) else $error("data bit not shifted in msb first");
   property p_por_ignore;
      @(posedge i_clk) disable iff (i_reset) !i_por_done |=> (cnt_q == 5'h00 && $stable(cfg_q));
   endproperty
   a_por_ignore: assert property (p_por_ignore) else $error("command taken during power-on reset");
   property p_no_partial;
      @(posedge i_clk) disable iff (i_reset) !commit |=> ($stable(cfg_q) && $stable(freq_q) && $stable(pwr_q));
   endproperty
   a_no_partial: assert property (p_no_partial) else $error("register changed without full command");
   property p_pll_default;
      @(posedge i_clk) $fell(i_reset) |-> o_pll_bandwidth_select == 2'b10;
   endproperty
   a_pll_default: assert property (p_pll_default) else $error("pll bandwidth default wrong");
   property p_power_db;
      @(posedge i_clk) disable iff (i_reset) o_power_atten_db <= 5'd21 && o_power_atten_db == 5'(o_power_step * 3);
   endproperty
   a_power_db: assert property (p_power_db) else $error("power attenuation not 3 dB per step");
   property p_tune_step;
      @(posedge i_clk) disable iff (i_reset) (tune_tick && tune_q < tune_target) |=> tune_q == $past(tune_q) + 3'h1;
   endproperty
   a_tune_step: assert property (p_tune_step) else $error("tuning did not step toward target");
   property p_fifo_bit;
      @(posedge i_clk) disable iff (i_reset) (shift_en && st_q == txscp_pkg::ST_FIFO) |=> (o_fifo_bit_valid && o_fifo_bit_data == $past(sdi_s2_q));
   endproperty
   a_fifo_bit: assert property (p_fifo_bit) else $error("fifo bit not forwarded");
   property p_stat_load;
      @(posedge i_clk) disable iff (i_reset) (active && $past(active) && $changed(st_q) && st_q == txscp_pkg::ST_STAT) |-> o_sdo == $past(i_status[15]);
   endproperty
   a_stat_load: assert property (p_stat_load) else $error("status msb not presented");
   property p_freq_range;
      @(posedge i_clk) disable iff (i_reset) (commit && cmd_q == txscp_pkg::CMD_FREQ
         && (word_d[11:0] < txscp_pkg::FREQ_MIN || word_d[11:0] > txscp_pkg::FREQ_MAX)) |=> $stable(freq_q);
   endproperty
   a_freq_range: assert property (p_freq_range) else $error("out of range frequency accepted");
   c_commit: cover property (@(posedge i_clk) disable iff (i_reset) commit);
   c_fifo:   cover property (@(posedge i_clk) disable iff (i_reset) o_fifo_bit_valid);
   c_stat:   cover property (@(posedge i_clk) disable iff (i_reset) st_q == txscp_pkg::ST_STAT ##1 st_q == txscp_pkg::ST_HOLD);
endmodule : txscp_top

// [pkg/txscp_pkg.sv]
package txscp_pkg;
   // clock and antenna tuning step rate
   localparam int CLK_PERIOD_NS    = 4;
   localparam int TUNE_STEP_NS     = 1000;
   localparam int TUNE_STEP_CYCLES = (TUNE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // transfer lengths in bits
   localparam logic [4:0] CMD_BITS  = 5'h08;
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [4:0] STAT_BITS = 5'h10;

   // power-on values of the command registers
   localparam logic [15:0] CFG_POR   = 16'h9082;
   localparam logic [15:0] FREQ_POR  = 16'hAD57;
   localparam logic [15:0] PWR_POR   = 16'hC002;
   localparam logic [15:0] FIFOS_POR = 16'hCE00;
   localparam logic [15:0] RATE_POR  = 16'hC813;
   localparam logic [15:0] BATT_POR  = 16'hC213;
   localparam logic [15:0] WAKE_POR  = 16'hE196;
   localparam logic [15:0] XWAKE_POR = 16'hC400;
   localparam logic [15:0] XFEAT_POR = 16'hB802;

   // parameter-bit masks; everything outside is fixed code or don't-care
   localparam logic [15:0] MASK_12  = 16'h0FFF;
   localparam logic [15:0] MASK_PWR = 16'h003F;
   localparam logic [15:0] MASK_FS  = 16'h00BF;
   localparam logic [15:0] MASK_8   = 16'h00FF;

   // command codes, upper nibble or full first byte
   localparam logic [3:0] NIB_CFG   = 4'h9;
   localparam logic [3:0] NIB_FREQ  = 4'hA;
   localparam logic [3:0] NIB_XFEAT = 4'hB;
   localparam logic [3:0] NIB_WAKE  = 4'hE;
   localparam logic [7:0] BYTE_PWR   = 8'hC0;
   localparam logic [7:0] BYTE_BATT  = 8'hC2;
   localparam logic [7:0] BYTE_XWAKE = 8'hC4;
   localparam logic [7:0] BYTE_FIFOW = 8'hC6;
   localparam logic [7:0] BYTE_RATE  = 8'hC8;
   localparam logic [7:0] BYTE_STAT  = 8'hCC;
   localparam logic [7:0] BYTE_FIFOS = 8'hCE;

   // field positions and limits
   localparam int          PWR_STEP_LSB = 8;
   localparam int          PLLBW_LSB    = 0;
   localparam int          TUNE_LSB     = 9;
   localparam logic [11:0] FREQ_MIN     = 12'h060;
   localparam logic [11:0] FREQ_MAX     = 12'hF3F;
   localparam logic [4:0]  DB_PER_STEP  = 5'h03;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_CFG, CMD_FREQ, CMD_PWR, CMD_FIFOW, CMD_FIFOS,
      CMD_RATE, CMD_BATT, CMD_WAKE, CMD_XWAKE, CMD_XFEAT, CMD_STAT
   } txscp_cmd_t;

   typedef enum logic [2:0] {ST_CMD, ST_PARAM, ST_FIFO, ST_STAT, ST_HOLD} txscp_state_t;

   // classify the first byte of a transfer
   function automatic txscp_cmd_t txscp_decode(input logic [7:0] b);
      txscp_cmd_t k;
      k = CMD_NONE;
      case (b[7:4])
         NIB_CFG:   k = CMD_CFG;
         NIB_FREQ:  k = CMD_FREQ;
         NIB_XFEAT: k = CMD_XFEAT;
         NIB_WAKE:  k = CMD_WAKE;
         default: begin
            case (b)
               BYTE_PWR:   k = CMD_PWR;
               BYTE_BATT:  k = CMD_BATT;
               BYTE_XWAKE: k = CMD_XWAKE;
               BYTE_FIFOW: k = CMD_FIFOW;
               BYTE_RATE:  k = CMD_RATE;
               BYTE_STAT:  k = CMD_STAT;
               BYTE_FIFOS: k = CMD_FIFOS;
               default:    k = CMD_NONE;
            endcase
         end
      endcase
      return k;
   endfunction : txscp_decode

   // keep fixed bits from the reset word, take parameter bits from the host
   function automatic logic [15:0] txscp_merge(input logic [15:0] por, input logic [15:0] mask,
                                               input logic [15:0] w);
      return (por & ~mask) | (w & mask);
   endfunction : txscp_merge
endpackage : txscp_pkg

// [tb/txscp_host.sv]
`timescale 1ns/10ps
// host side of the serial command link; sck stands still low between frames
module txscp_host (
   input  wire logic i_clk,
   input  wire logic i_sdo,
   output logic      o_select_n,
   output logic      o_sck,
   output logic      o_sdi
);
   int half = 4;  // clocks per sck phase, never below 3

   initial begin
      o_select_n = 1'b1;
      o_sck      = 1'b0;
      o_sdi      = 1'b0;
   end

   // shift n bits of w msb first; bits past the command byte also pick up sdo
   task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      @(negedge i_clk);
      o_select_n = 1'b0;
      repeat (half) @(negedge i_clk);
      for (int i = n - 1; i >= 0; i--) begin
         o_sdi = w[i];
         repeat (half) @(negedge i_clk);
         if (n - i > 8) rd = {rd[14:0], i_sdo};  // sampled just before the rise
         o_sck = 1'b1;
         repeat (half) @(negedge i_clk);
         o_sck = 1'b0;
      end
      repeat (half) @(negedge i_clk);
      o_select_n = 1'b1;
      o_sdi      = ~o_sdi;  // released line must not hold its last value
      repeat (4) @(negedge i_clk);
   endtask : xfer
endmodule : txscp_host

// [tb/txscp_tb_top.sv]
`timescale 1ns/10ps
module txscp_tb_top;
   localparam logic [15:0] POR_W [9] = '{txscp_pkg::CFG_POR, txscp_pkg::FREQ_POR, txscp_pkg::PWR_POR,
      txscp_pkg::FIFOS_POR, txscp_pkg::RATE_POR, txscp_pkg::BATT_POR, txscp_pkg::WAKE_POR,
      txscp_pkg::XWAKE_POR, txscp_pkg::XFEAT_POR};
   localparam logic [15:0] MSK [9] = '{16'h0FFF, 16'h0FFF, 16'h003F, 16'h00BF, 16'h00FF, 16'h00FF,
      16'h0FFF, 16'h00FF, 16'h00FF};
   logic        clk;
   logic        reset;
   logic        por_done;
   logic        select_n;
   logic        sck;
   logic        sdi;
   logic        sdo;
   logic [15:0] status;
   logic [15:0] word [9];
   logic [15:0] exp_w [9];
   logic [1:0]  pll;
   logic [2:0]  step;
   logic [4:0]  atten;
   logic [2:0]  tune;
   logic        fifo_valid;
   logic        fifo_data;
   logic [15:0] fifo_got;
   logic [15:0] rd;
   int          fifo_cnt;
   int          n_tests;
   int          miscompares;
   int          cyc;

   txscp_top i_dut (.i_clk(clk), .i_reset(reset), .i_por_done(por_done), .i_select_n(select_n),
      .i_sck(sck), .i_sdi(sdi), .i_status(status), .o_sdo(sdo), .o_cfg_word(word[0]),
      .o_freq_word(word[1]), .o_pwr_word(word[2]), .o_fifo_set_word(word[3]), .o_rate_word(word[4]),
      .o_batt_word(word[5]), .o_wake_word(word[6]), .o_xwake_word(word[7]), .o_xfeat_word(word[8]),
      .o_pll_bandwidth_select(pll), .o_power_step(step), .o_power_atten_db(atten),
      .o_tune_state(tune), .o_fifo_bit_valid(fifo_valid), .o_fifo_bit_data(fifo_data));

   txscp_host i_host (.i_clk(clk), .i_sdo(sdo), .o_select_n(select_n), .o_sck(sck), .o_sdi(sdi));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // fifo bits collected msb first, sampled mid-cycle where the pulse has settled
   always @(negedge clk) begin
      cyc++;
      if (fifo_valid === 1'b1) begin
         fifo_got = {fifo_got[14:0], fifo_data};
         fifo_cnt++;
      end
      if (cyc == 60000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // every register plus the pll, power step and attenuation fields derived from them; tune state is checked separately
   task automatic chk_all();
      for (int k = 0; k < 9; k++) chk(word[k], exp_w[k], "word");
      chk({14'h0000, pll}, {14'h0000, exp_w[8][1:0]}, "pll bandwidth");
      chk({13'h0000, step}, {13'h0000, exp_w[0][10:8]}, "power step");
      chk({11'h0000, atten}, 16'(exp_w[0][10:8] * 3), "attenuation");
   endtask : chk_all

   // send one 16-bit command; freq words outside 96..3903 are kept out
   task automatic cmd(input int k, input logic [15:0] p);
      logic [15:0] w;
      w = (POR_W[k] & ~MSK[k]) | (p & MSK[k]);
      i_host.half = 3 + ($urandom % 4);
      i_host.xfer({16'h0000, w}, 16, rd);
      if (k != 1 || (w[11:0] >= 12'h060 && w[11:0] <= 12'hF3F)) exp_w[k] = w;
      repeat (8) @(negedge clk);
      chk_all();
   endtask : cmd

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      reset       = 1'b1;
      por_done    = 1'b0;
      status      = 16'h0000;
      fifo_got    = 16'h0000;
      fifo_cnt    = 0;
      n_tests     = 0;
      miscompares = 0;
      cyc         = 0;
      void'($urandom(9786));
      exp_w = POR_W;
      repeat (16) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      chk_all();
      // commands before the power-on pulse ends are dropped
      i_host.xfer({16'h0000, 16'h9F55}, 16, rd);
      repeat (8) @(negedge clk);
      chk_all();
      por_done = 1'b1;
      for (int k = 0; k < 9; k++) cmd(k, 16'($urandom));
      for (int r = 0; r < 20; r++) cmd($urandom % 9, 16'($urandom));
      for (int s = 0; s < 8; s++) cmd(0, {5'h00, 3'(s), 8'($urandom)});
      for (int b = 0; b < 4; b++) cmd(8, {14'($urandom), 2'(b)});
      // frequency bounds, with the tuning state allowed time to settle
      cmd(1, 16'h0F3F);
      repeat (2200) @(negedge clk);
      chk({13'h0000, tune}, 16'h0007, "tune state");
      cmd(1, 16'h0F40);
      cmd(1, 16'h005F);
      cmd(1, 16'h0060);
      repeat (2200) @(negedge clk);
      chk({13'h0000, tune}, 16'h0000, "tune state");
      // cut-short transfers and an unknown code leave everything alone
      i_host.xfer({20'h0000, 12'h9F5}, 12, rd);
      i_host.xfer({16'h0000, 16'h0155}, 16, rd);
      i_host.xfer({24'h0000, 8'hA5}, 8, rd);
      repeat (8) @(negedge clk);
      chk_all();
      // status read: 16 bits come back after the command byte
      for (int r = 0; r < 3; r++) begin
         status = 16'($urandom);
         i_host.xfer({8'h00, 8'hCC, 16'h0000}, 24, rd);
         chk(rd, status, "status read");
      end
      // fifo write carries any bit count, here 13
      fifo_cnt = 0;
      i_host.xfer({11'h000, 8'hC6, 13'h1ACB}, 21, rd);
      repeat (8) @(negedge clk);
      chk(16'(fifo_cnt), 16'h000D, "fifo bit count");
      chk({3'h0, fifo_got[12:0]}, 16'h1ACB, "fifo bits");
      chk_all();
      end_of_test();
   end
endmodule : txscp_tb_top
